// *** design/fofu_map.svh ***
`ifndef FOFU_MAP_SVH
`define FOFU_MAP_SVH

// ----------------------------------------
// word layout
// ----------------------------------------
`define FOFU_WORD_W 24
`define FOFU_FP_W 48
`define FOFU_COEF_W 36
`define FOFU_SIGN_BIT 47
`define FOFU_EXP_MSB 46
`define FOFU_EXP_LSB 36
`define FOFU_FIX_SIGN 23
`define FOFU_ADDR_W 15

// ----------------------------------------
// exponent bias and range
// ----------------------------------------
`define FOFU_BIAS_POS 13'h0400
`define FOFU_BIAS_NEG 13'h03ff
`define FOFU_EXP_MAX 13'h03ff
`define FOFU_EXP_MIN 13'h1c01
`define FOFU_FIX_EXP 13'h0017

// ----------------------------------------
// alignment shifter
// ----------------------------------------
`define FOFU_SHIFT_MAX 13'h003f
`define FOFU_SHIFT_LIMIT 13'h0024

`endif

// *** design/fofu_pkg.sv ***
package fofu_pkg;

	typedef enum logic [3:0] {
		FOFU_OP_LOAD = 4'h0,
		FOFU_OP_STORE = 4'h1,
		FOFU_OP_ADD = 4'h2,
		FOFU_OP_SUB = 4'h3,
		FOFU_OP_DIV = 4'h4,
		FOFU_OP_DMUL = 4'h5,
		FOFU_OP_DDIV = 4'h6,
		FOFU_OP_FIX = 4'h7
	} fofu_op_t;

	typedef enum logic [3:0] {
		FOFU_S_IDLE = 4'h0,
		FOFU_S_INDIR = 4'h1,
		FOFU_S_RD_HI = 4'h2,
		FOFU_S_RD_LO = 4'h3,
		FOFU_S_WR_HI = 4'h4,
		FOFU_S_WR_LO = 4'h5,
		FOFU_S_EXEC = 4'h6,
		FOFU_S_NORM = 4'h7
	} fofu_st_t;

	typedef struct packed {
		fofu_st_t st;
		fofu_op_t op;
		logic [14:0] addr;
		logic [47:0] aq;
		logic [47:0] ext;
		logic [47:0] opnd;
		logic neg;
		logic [37:0] mag;
		logic [12:0] exp;
		logic [2:0] fault;
		logic [2:0] sensed;
		logic trap;
		logic disp;
		logic done;
		logic [10:0] xbiased;
		logic xrange;
	} fofu_state_t;

endpackage : fofu_pkg

// *** design/fofu_dp_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// exponent bias channel
interface fofu_bias_if;
	logic ones;
	logic [12:0] true_val;
	logic [10:0] biased;
	logic range_err;
	modport user (output ones, output true_val, input biased, input range_err);
	modport unit (input ones, input true_val, output biased, output range_err);
endinterface : fofu_bias_if

// align and add channel
interface fofu_align_if;
	logic [37:0] a_coef;
	logic [37:0] b_coef;
	logic [12:0] a_exp;
	logic [12:0] b_exp;
	logic [37:0] sum;
	logic [12:0] exp;
	logic [35:0] residue;
	modport user (output a_coef, output b_coef, output a_exp, output b_exp, input sum, input exp, input residue);
	modport unit (input a_coef, input b_coef, input a_exp, input b_exp, output sum, output exp, output residue);
endinterface : fofu_align_if

`default_nettype wire

// *** design/fofu_exp_bias.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fofu_map.svh"

module fofu_exp_bias
(
	fofu_bias_if.unit b
);

	logic [12:0] t2;
	logic [12:0] tmp;

	always_comb
	begin
		if (b.ones && b.true_val == 13'h1fff)
			t2 = 13'h0000;
		else if (b.ones && b.true_val[12])
			t2 = b.true_val + 13'h0001;
		else
			t2 = b.true_val;
		tmp = t2 + (t2[12] ? `FOFU_BIAS_NEG : `FOFU_BIAS_POS);
	end

	assign b.biased = tmp[10:0];
	assign b.range_err = ($signed(t2) > $signed(`FOFU_EXP_MAX)) || ($signed(t2) < $signed(`FOFU_EXP_MIN));

endmodule : fofu_exp_bias

`default_nettype wire

// *** design/fofu_align_add.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fofu_map.svh"

module fofu_align_add #(
	parameter int SHIFT_MAX = 63
)
(
	fofu_align_if.unit a
);

	if (SHIFT_MAX < 36 || SHIFT_MAX > 63)
		$error("fofu_align_add: SHIFT_MAX must lie in 36..63");

	logic a_big;
	logic [12:0] diff;
	logic [5:0] amt;
	logic [37:0] big_c;
	logic [73:0] shifted;
	logic [38:0] raw;

	always_comb
	begin
		a_big = $signed(a.a_exp) >= $signed(a.b_exp);
		diff = a_big ? a.a_exp - a.b_exp : a.b_exp - a.a_exp;
		big_c = a_big ? a.a_coef : a.b_coef;
		amt = (diff > 13'(SHIFT_MAX)) ? 6'(SHIFT_MAX) : diff[5:0];
		shifted = $signed({(a_big ? a.b_coef : a.a_coef), 36'h0}) >>> amt;
		raw = {1'b0, big_c} + {1'b0, shifted[73:36]};
		a.sum = raw[37:0] + {37'h0, raw[38]};
		a.residue = shifted[35:0];
		if (diff > `FOFU_SHIFT_LIMIT)
		begin
			a.sum = big_c;
			a.residue = 36'h0;
		end
		a.exp = a_big ? a.a_exp : a.b_exp;
	end

endmodule : fofu_align_add

`default_nettype wire

// *** design/fofu_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fofu_map.svh"

module fofu_top
	import fofu_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire fofu_op_t cmd_op_i,
	input wire logic [14:0] cmd_addr_i,
	input wire logic [14:0] cmd_index_i,
	input wire logic cmd_indirect_i,
	input wire logic arith_option_i,
	output logic cmd_ready_o,
	output logic done_o,
	output logic trap_o,
	output logic dispatch_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [14:0] mem_addr_o,
	output logic [23:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [23:0] mem_rdata_i,
	output logic [47:0] aq_o,
	output logic [47:0] ext_o,
	input wire logic [2:0] sense_i,
	output logic [2:0] sense_hit_o,
	output logic [2:0] fault_o,
	input wire logic [11:0] exp_true_i,
	output logic [10:0] exp_biased_o,
	output logic exp_range_err_o
);

	localparam int FAULT_OVF = 0;
	localparam int FAULT_UNF = 1;
	localparam int FAULT_DIV = 2;

	fofu_state_t q;
	fofu_state_t next_q;

	fofu_align_if al ();
	fofu_bias_if res_bias ();
	fofu_bias_if port_bias ();

	fofu_align_add #(
		.SHIFT_MAX(63)
	) u_align (
		.a(al.unit)
	);

	fofu_exp_bias u_res_bias (
		.b(res_bias.unit)
	);

	fofu_exp_bias u_port_bias (
		.b(port_bias.unit)
	);

	// ----------------------------------------
	// operand decode
	// ----------------------------------------
	function automatic logic [12:0] fofu_unbias(input logic [10:0] be);
		fofu_unbias = be[10] ? {2'b00, be} - `FOFU_BIAS_POS : {2'b00, be} - `FOFU_BIAS_NEG;
	endfunction : fofu_unbias

	// one's complement coefficient, sign extended to 38 bits
	function automatic logic [37:0] fofu_coef(input logic [47:0] w);
		logic [47:0] m;
		m = w[`FOFU_SIGN_BIT] ? ~w : w;
		fofu_coef = w[`FOFU_SIGN_BIT] ? ~{2'b00, m[35:0]} : {2'b00, m[35:0]};
	endfunction : fofu_coef

	function automatic logic [10:0] fofu_exp_field(input logic [47:0] w);
		logic [47:0] m;
		m = w[`FOFU_SIGN_BIT] ? ~w : w;
		fofu_exp_field = m[`FOFU_EXP_MSB:`FOFU_EXP_LSB];
	endfunction : fofu_exp_field

	logic [47:0] b_word;
	logic [15:0] idx_sum;
	logic [14:0] eff_addr;
	logic [37:0] div_mag;
	logic [22:0] fix_mag;

	always_comb
	begin
		b_word = (q.op == FOFU_OP_SUB) ? ~q.opnd : q.opnd;
		al.a_coef = fofu_coef(q.aq);
		al.b_coef = fofu_coef(b_word);
		al.a_exp = fofu_unbias(fofu_exp_field(q.aq));
		al.b_exp = fofu_unbias(fofu_exp_field(b_word));
		idx_sum = {1'b0, cmd_addr_i} + {1'b0, cmd_index_i};
		eff_addr = idx_sum[14:0] + {14'h0, idx_sum[15]};
		div_mag = fofu_coef(q.opnd[`FOFU_SIGN_BIT] ? ~q.opnd : q.opnd);
		fix_mag = q.aq[47] ? ~q.aq[46:24] : q.aq[46:24];
		res_bias.ones = 1'b0;
		res_bias.true_val = q.exp;
		port_bias.ones = 1'b1;
		port_bias.true_val = {exp_true_i[11], exp_true_i};
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb
	begin
		next_q = q;
		next_q.trap = 1'b0;
		next_q.disp = 1'b0;
		next_q.done = 1'b0;
		next_q.xbiased = port_bias.biased;
		next_q.xrange = port_bias.range_err;
		// sense clears sensed faults
		// a fault raised further down overrides this clear
		next_q.sensed = q.fault & sense_i;
		next_q.fault = q.fault & ~sense_i;
		case (q.st)
			FOFU_S_IDLE:
			begin
				if (cmd_valid_i)
				begin
					next_q.op = cmd_op_i;
					next_q.addr = eff_addr;
					case (cmd_op_i)
						FOFU_OP_DMUL, FOFU_OP_DDIV:
						begin
							next_q.trap = !arith_option_i;
							next_q.disp = arith_option_i;
							next_q.done = 1'b1;
						end
						FOFU_OP_FIX:
							next_q.st = FOFU_S_EXEC;
						FOFU_OP_STORE:
							next_q.st = cmd_indirect_i ? FOFU_S_INDIR : FOFU_S_WR_HI;
						default:
							next_q.st = cmd_indirect_i ? FOFU_S_INDIR : FOFU_S_RD_HI;
					endcase
				end
			end
			FOFU_S_INDIR:
			begin
				if (mem_ack_i)
				begin
					next_q.addr = mem_rdata_i[14:0];
					next_q.st = (q.op == FOFU_OP_STORE) ? FOFU_S_WR_HI : FOFU_S_RD_HI;
				end
			end
			FOFU_S_RD_HI:
			begin
				if (mem_ack_i)
				begin
					next_q.opnd[47:24] = mem_rdata_i;
					next_q.addr = q.addr + 15'h0001;
					next_q.st = FOFU_S_RD_LO;
				end
			end
			FOFU_S_RD_LO:
			begin
				if (mem_ack_i)
				begin
					next_q.opnd[23:0] = mem_rdata_i;
					next_q.st = FOFU_S_EXEC;
				end
			end
			FOFU_S_WR_HI:
			begin
				if (mem_ack_i)
				begin
					next_q.addr = q.addr + 15'h0001;
					next_q.st = FOFU_S_WR_LO;
				end
			end
			FOFU_S_WR_LO:
			begin
				if (mem_ack_i)
				begin
					next_q.done = 1'b1;
					next_q.st = FOFU_S_IDLE;
				end
			end
			FOFU_S_EXEC:
			begin
				next_q.st = FOFU_S_IDLE;
				case (q.op)
					FOFU_OP_LOAD:
					begin
						next_q.aq = q.opnd;
						next_q.done = 1'b1;
					end
					FOFU_OP_ADD, FOFU_OP_SUB:
					begin
						next_q.neg = al.sum[37];
						next_q.mag = al.sum[37] ? ~al.sum : al.sum;
						next_q.exp = al.exp;
						next_q.ext = {al.residue, 12'h000};
						next_q.st = FOFU_S_NORM;
					end
					FOFU_OP_DIV:
					begin
						if (!div_mag[35])
							next_q.fault[FAULT_DIV] = 1'b1;
						else
							next_q.disp = 1'b1;
						next_q.done = 1'b1;
					end
					FOFU_OP_FIX:
					begin
						next_q.neg = q.aq[`FOFU_SIGN_BIT];
						next_q.mag = {2'b00, fix_mag, 13'h0000};
						next_q.exp = `FOFU_FIX_EXP;
						next_q.ext = 48'h0;
						next_q.st = FOFU_S_NORM;
					end
					default:
						next_q.done = 1'b1;
				endcase
			end
			FOFU_S_NORM:
			begin
				if (q.mag == 38'h0)
				begin
					next_q.aq = 48'h0;
					next_q.done = 1'b1;
					next_q.st = FOFU_S_IDLE;
				end
				else if (q.mag[36])
				begin
					next_q.mag = q.mag >> 1;
					next_q.exp = q.exp + 13'h0001;
				end
				else if (!q.mag[35])
				begin
					next_q.mag = q.mag << 1;
					next_q.exp = q.exp - 13'h0001;
				end
				else
				begin
					next_q.done = 1'b1;
					next_q.st = FOFU_S_IDLE;
					if ($signed(q.exp) > $signed(`FOFU_EXP_MAX))
						next_q.fault[FAULT_OVF] = 1'b1;
					else if ($signed(q.exp) < $signed(`FOFU_EXP_MIN))
						next_q.fault[FAULT_UNF] = 1'b1;
					else
					begin
						next_q.aq = q.neg ? ~{1'b0, res_bias.biased, q.mag[35:0]}
							: {1'b0, res_bias.biased, q.mag[35:0]};
					end
				end
			end
			default:
				next_q.st = FOFU_S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			q <= '0;
		else
			q <= next_q;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign cmd_ready_o = (q.st == FOFU_S_IDLE);
	assign mem_req_o = (q.st == FOFU_S_INDIR) || (q.st == FOFU_S_RD_HI) || (q.st == FOFU_S_RD_LO)
		|| (q.st == FOFU_S_WR_HI) || (q.st == FOFU_S_WR_LO);
	assign mem_we_o = (q.st == FOFU_S_WR_HI) || (q.st == FOFU_S_WR_LO);
	assign mem_addr_o = q.addr;
	assign mem_wdata_o = (q.st == FOFU_S_WR_LO) ? q.aq[23:0] : q.aq[47:24];
	assign done_o = q.done;
	assign trap_o = q.trap;
	assign dispatch_o = q.disp;
	assign aq_o = q.aq;
	assign ext_o = q.ext;
	assign fault_o = q.fault;
	assign sense_hit_o = q.sensed;
	assign exp_biased_o = q.xbiased;
	assign exp_range_err_o = q.xrange;

endmodule : fofu_top

`default_nettype wire

// *** verification/fofu_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module fofu_top_asserts
	import fofu_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire fofu_op_t cmd_op_i,
	input wire logic arith_option_i,
	input wire logic cmd_ready_o,
	input wire logic done_o,
	input wire logic trap_o,
	input wire logic dispatch_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [14:0] mem_addr_o,
	input wire logic [23:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [2:0] sense_i,
	input wire logic [2:0] sense_hit_o,
	input wire logic [2:0] fault_o,
	input wire logic [11:0] exp_true_i,
	input wire logic [10:0] exp_biased_o,
	input wire logic exp_range_err_o
);
	logic [11:0] prev_exp;
	logic [2:0] prev_keep;

	always_ff @(posedge clk_sys_i)
	begin
		prev_exp <= exp_true_i;
		prev_keep <= fault_o & ~sense_i;
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_dbl;
		cmd_valid_i && cmd_ready_o && (cmd_op_i == FOFU_OP_DMUL || cmd_op_i == FOFU_OP_DDIV);
	endsequence

	sequence s_wr_step;
		mem_req_o && mem_we_o && mem_ack_i ##1 mem_req_o && mem_we_o;
	endsequence

	a_trap_no_option: assert property (s_dbl ##0 !arith_option_i |=> trap_o && done_o && !dispatch_o)
		else $error("double op without option did not trap");
	a_opt_dispatch: assert property (s_dbl ##0 arith_option_i |=> dispatch_o && done_o && !trap_o)
		else $error("double op with option not dispatched");
	a_bias_pos: assert property (!exp_true_i[11] && !exp_true_i[10] |=> exp_biased_o == {1'b1, prev_exp[9:0]})
		else $error("positive exponent bias wrong");
	a_bias_neg: assert property (exp_true_i[11] && exp_true_i[10] && exp_true_i != 12'hfff
		|=> exp_biased_o == {1'b0, prev_exp[9:0]})
		else $error("negative exponent bias wrong");
	a_minus_zero: assert property (exp_true_i == 12'hfff |=> exp_biased_o == 11'h400)
		else $error("minus zero exponent bias wrong");
	a_exp_range: assert property (1'b1 |=> exp_range_err_o == (prev_exp[11] ^ prev_exp[10]))
		else $error("exponent range flag wrong");
	a_sense_hit: assert property (1'b1 |=> sense_hit_o == ($past(sense_i) & $past(fault_o)))
		else $error("sense hit wrong");
	a_fault_sticky: assert property (1'b1 |=> (fault_o & prev_keep) == prev_keep)
		else $error("fault dropped without sense");
	a_mem_hold: assert property (mem_req_o && !mem_ack_i
		|=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
		else $error("storage request changed before ack");
	a_store_pair: assert property (s_wr_step |-> mem_addr_o == $past(mem_addr_o) + 15'h1)
		else $error("second storage word not at next address");
endmodule : fofu_top_asserts

bind fofu_top fofu_top_asserts u_asserts (.clk_sys_i, .rst_n_i, .cmd_valid_i, .cmd_op_i, .arith_option_i,
	.cmd_ready_o, .done_o, .trap_o, .dispatch_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
	.mem_ack_i, .sense_i, .sense_hit_o, .fault_o, .exp_true_i, .exp_biased_o, .exp_range_err_o);

`default_nettype wire

// *** verification/fofu_store_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module fofu_store_model
(
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [14:0] addr_i,
	input wire logic [23:0] wdata_i,
	input wire logic [3:0] wait_i,
	output logic ack_o,
	output logic [23:0] rdata_o
);
	logic [23:0] mem [0:32767];
	logic [23:0] last = 24'h0;
	logic [3:0] cnt = 4'h0;

	// one word per address, answered after wait_i cycles
	assign ack_o = req_i && cnt >= wait_i;
	// data line does not keep the last word once released
	assign rdata_o = ack_o ? mem[addr_i] : ~last;

	always @(posedge clk_i)
	begin
		if (ack_o)
		begin
			cnt <= 4'h0;
			last <= rdata_o;
			if (we_i)
				mem[addr_i] <= wdata_i;
		end
		else if (req_i)
			cnt <= cnt + 4'h1;
	end
endmodule : fofu_store_model

`default_nettype wire

// *** verification/float_fixed_operand_format_unit_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module float_fixed_operand_format_unit_test;
	import fofu_pkg::*;

	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	fofu_op_t cmd_op_i = FOFU_OP_LOAD;
	logic [14:0] cmd_addr_i = 15'h0, cmd_index_i = 15'h0;
	logic cmd_indirect_i = 1'b0, arith_option_i = 1'b0;
	logic [2:0] sense_i = 3'h0;
	logic [11:0] exp_true_i = 12'h0;
	logic [3:0] mem_wait = 4'h0;
	logic cmd_ready_o, done_o, trap_o, dispatch_o, mem_req_o, mem_we_o, mem_ack_i, exp_range_err_o;
	logic [14:0] mem_addr_o;
	logic [23:0] mem_wdata_o, mem_rdata_i;
	logic [47:0] aq_o, ext_o;
	logic [2:0] sense_hit_o, fault_o;
	logic [10:0] exp_biased_o;
	int error_cnt = 0, n_tests = 0;
	localparam logic [47:0] X = 48'h428800000000;

	always #5 clk_sys_i = ~clk_sys_i;

	fofu_top dut (.clk_sys_i, .rst_n_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i, .cmd_index_i, .cmd_indirect_i,
		.arith_option_i, .cmd_ready_o, .done_o, .trap_o, .dispatch_o, .mem_req_o, .mem_we_o, .mem_addr_o,
		.mem_wdata_o, .mem_ack_i, .mem_rdata_i, .aq_o, .ext_o, .sense_i, .sense_hit_o, .fault_o,
		.exp_true_i, .exp_biased_o, .exp_range_err_o);

	fofu_store_model mdl (.clk_i(clk_sys_i), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
		.wdata_i(mem_wdata_o), .wait_i(mem_wait), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

	task automatic give_verdict;
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic put(input logic [14:0] a, input logic [47:0] w);
		mdl.mem[a] = w[47:24];
		mdl.mem[a + 15'h1] = w[23:0];
	endtask : put

	task automatic run(input fofu_op_t op, input logic [14:0] a);
		@(negedge clk_sys_i);
		cmd_op_i = op;
		cmd_addr_i = a;
		cmd_valid_i = 1'b1;
		@(negedge clk_sys_i);
		cmd_valid_i = 1'b0;
		for (int i = 0; i < 200 && done_o !== 1'b1; i++)
			@(negedge clk_sys_i);
		if (done_o !== 1'b1)
		begin
			error_cnt++;
			give_verdict();
		end
	endtask : run

	task automatic lda(input logic [14:0] a, input logic [47:0] w);
		put(15'h100, w);
		run(FOFU_OP_LOAD, a);
		check(aq_o, w); // loaded pair, first word high
	endtask : lda

	task automatic sense(input logic [2:0] s, input logic [2:0] hit);
		@(negedge clk_sys_i);
		check(fault_o, hit); // fault pending
		sense_i = s;
		@(negedge clk_sys_i);
		sense_i = 3'h0;
		check({sense_hit_o, fault_o}, {hit, 3'h0}); // sensed and cleared
	endtask : sense

	task automatic t_exp;
		logic [11:0] tv [8] = '{12'h000, 12'hfff, 12'h001, 12'h3ff, 12'hffe, 12'hc00, 12'h400, 12'hbff};
		logic [10:0] bv [6] = '{11'h400, 11'h400, 11'h401, 11'h7ff, 11'h3fe, 11'h000};
		for (int i = 0; i < 8; i++)
		begin
			@(negedge clk_sys_i);
			exp_true_i = tv[i];
			@(negedge clk_sys_i);
			check(exp_range_err_o, i > 5); // range flag
			if (i < 6)
				check(exp_biased_o, bv[i]); // biased value
		end
	endtask : t_exp

	task automatic t_dbl;
		for (int i = 0; i < 4; i++)
		begin
			arith_option_i = i[1];
			run(i[0] ? FOFU_OP_DDIV : FOFU_OP_DMUL, 15'h0);
			check({trap_o, dispatch_o}, {~i[1], i[1]}); // trap or hand-off
		end
		arith_option_i = 1'b0;
	endtask : t_dbl

	task automatic t_load_store;
		mem_wait = 4'h3;
		lda(15'h100, 48'h428800000001); // slow storage
		mem_wait = 4'h0;
		cmd_index_i = 15'h0f0;
		lda(15'h010, 48'h400800000002); // indexed address
		cmd_index_i = 15'h0;
		cmd_indirect_i = 1'b1;
		put(15'h200, 48'h000100000000);
		lda(15'h200, 48'h7ff800000003); // indirect address
		cmd_indirect_i = 1'b0;
		mem_wait = 4'h2;
		run(FOFU_OP_STORE, 15'h300);
		mem_wait = 4'h0;
		check({mdl.mem[15'h300], mdl.mem[15'h301]}, 48'h7ff800000003); // same layout
	endtask : t_load_store

	task automatic t_add;
		lda(15'h100, X);
		put(15'h110, 48'h400800000000);
		run(FOFU_OP_ADD, 15'h110);
		check(aq_o, X); // shift beyond coefficient
		put(15'h110, X);
		run(FOFU_OP_ADD, 15'h110);
		check(aq_o, 48'h429800000000); // carry out renormalised
		lda(15'h100, X);
		put(15'h110, ~X);
		run(FOFU_OP_ADD, 15'h110);
		check(aq_o, 48'h0); // zero sum is plus zero
		lda(15'h100, X);
		put(15'h110, 48'h427800000001);
		run(FOFU_OP_ADD, 15'h110);
		check(aq_o, 48'h428c00000000); // one place alignment
		check(ext_o, 48'h800000000000); // shifted-out bit in extension
		lda(15'h100, X);
		put(15'h110, 48'h427800000000);
		run(FOFU_OP_SUB, 15'h110);
		check(aq_o, 48'h427800000000); // subtract with end-around carry
		lda(15'h100, 48'h7ff800000000);
		put(15'h110, 48'h7ff800000000);
		run(FOFU_OP_ADD, 15'h110);
		sense(3'h1, 3'h1); // exponent overflow
		lda(15'h100, 48'h000800000000);
		put(15'h110, 48'h000c00000000);
		run(FOFU_OP_SUB, 15'h110);
		sense(3'h2, 3'h2); // exponent underflow
	endtask : t_add

	task automatic t_div_fix;
		put(15'h120, 48'h0);
		run(FOFU_OP_DIV, 15'h120);
		check(dispatch_o, 1'b0); // zero divisor kept back
		sense(3'h5, 3'h4); // divide fault
		put(15'h120, X);
		run(FOFU_OP_DIV, 15'h120);
		check(dispatch_o, 1'b1); // valid divisor
		lda(15'h100, 48'h000004000000);
		run(FOFU_OP_FIX, 15'h0);
		check(aq_o, 48'h403800000000); // integer to float
		lda(15'h100, 48'hfffffb000000);
		run(FOFU_OP_FIX, 15'h0);
		check(aq_o, 48'hbfc7ffffffff); // negative whole word complemented
	endtask : t_div_fix

	initial
	begin
		repeat (2) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		t_exp();
		t_dbl();
		t_load_store();
		t_add();
		t_div_fix();
		give_verdict();
	end
endmodule : float_fixed_operand_format_unit_test

`default_nettype wire
